// *** common/vector_packet_formatter_cfg.svh ***
// constants of the vector packet formatter: register offsets, bit
// positions, reset values and code points.
// assumes it is included by bare name after the package or a module header.
`ifndef VECTOR_PACKET_FORMATTER_CFG_SVH
`define VECTOR_PACKET_FORMATTER_CFG_SVH

// wishbone register byte offsets
`define REG_CTRL 8'h00
`define REG_IRQ_STATUS 8'h04
`define REG_IRQ_MASK 8'h08
`define REG_LAST_PKT 8'h0C
`define REG_PKT_COUNT 8'h10
`define REG_LEVEL 8'h14

// control bits
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 2'h0
`define CTRL_WIDTH 2
`define CTRL_FLUSH_BIT 1

// interrupt bits, same layout in status and mask
`define IRQ_WIDTH 3
`define IRQ_SENT_BIT 0
`define IRQ_VEC_ERR_BIT 1
`define IRQ_DROP_BIT 2
`define IRQ_RESET 3'h0

// vector type codes in byte 2 bits 2..0
`define VT_SECURE 3'h0
`define VT_SHORT_INSTR 3'h1
`define VT_ALPHA 3'h5
`define VT_HEX 3'h6

// instruction type codes
`define IT_TEMP_ADDR 3'h0
`define IT_EVENT 3'h1
`define IT_TEMP_SEQ 3'h2

// packet geometry
`define PKT_BITS 32
`define BIT_CNT_LAST 5'h1F
`define PKT_RESET 32'h0000_0000

`endif

// *** common/vector_packet_formatter_pkg.sv ***
// types shared by the vector packet formatter and its two helpers.
// assumes the decoder upstream fills the word structs on the same clock.
`default_nettype none

package vector_packet_formatter_pkg;

  typedef logic [6:0] word_pos_t;
  typedef logic [31:0] packet_t;

  // one decoded vector word with everything a packet needs
  typedef struct packed {
    word_pos_t vector_word_position;
    logic [1:0] phase;
    logic [2:0] vtype;
    logic long_addr;
    logic bit_err_gt2;
    logic check_fail;
    logic invalid;
    logic [6:0] msg_len;
    word_pos_t msg_start;
    logic [2:0] itype;
    logic [3:0] tmp_addr;
    logic [6:0] frame;
    logic [10:0] events;
    logic [5:0] message_sequence_number;
  } vector_in_s;

  // one decoded message word
  typedef struct packed {
    word_pos_t vector_word_position;
    logic [1:0] phase;
    logic bit_err_gt2;
    logic [20:0] info;
  } msg_in_s;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b01,
    LINK_SHIFT = 2'b10
  } link_state_e;

endpackage

`default_nettype wire

// *** verilog/msg_window.sv ***
// message word window: remembers which frame word positions belong to
// the last loaded vector if it was error-free. assumes one vector load per frame per address.
`default_nettype none
`include "vector_packet_formatter_cfg.svh"

module msg_window (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire vector_packet_formatter_pkg::vector_in_s vec_i,
  input wire logic vec_err_i,
  input wire logic clear_i,
  input wire logic query_i,
  input wire vector_packet_formatter_pkg::word_pos_t pos_i,
  output logic match_o
);

  logic first_pend;
  vector_packet_formatter_pkg::word_pos_t first_pos;
  vector_packet_formatter_pkg::word_pos_t range_start;
  logic [6:0] range_count;
  logic next_first_pend;
  vector_packet_formatter_pkg::word_pos_t next_first_pos;
  vector_packet_formatter_pkg::word_pos_t next_range_start;
  logic [6:0] next_range_count;
  logic is_long_msg;
  logic first_hit;
  logic range_hit;
  logic [7:0] range_end;

  // long-message vector types own a message field
  assign is_long_msg = (vec_i.vtype == `VT_SECURE) ||
                       (vec_i.vtype == `VT_ALPHA) ||
                       (vec_i.vtype == `VT_HEX);
  assign range_end = {1'b0, range_start} + {1'b0, range_count};
  assign first_hit = first_pend && (pos_i == first_pos);
  assign range_hit = (range_count != 7'h00) && (pos_i >= range_start) &&
                     ({1'b0, pos_i} < range_end);
  assign match_o = first_hit || range_hit;

  // window update; a new vector replaces the old window outright
  always_comb begin
    next_first_pend = first_pend;
    next_first_pos = first_pos;
    next_range_start = range_start;
    next_range_count = range_count;
    if (clear_i) begin
      next_first_pend = 1'b0;
      next_range_count = 7'h00;
    end else if (load_i) begin
      next_first_pend = 1'b0;
      next_range_count = 7'h00;
      next_first_pos = vec_i.vector_word_position + 7'h01;
      next_range_start = vec_i.msg_start;
      if (!vec_err_i && is_long_msg && vec_i.msg_len != 7'h00) begin
        // long address: first word right after the vector, b marks word two
        if (vec_i.long_addr) begin
          next_first_pend = 1'b1;
          next_range_count = vec_i.msg_len - 7'h01;
        end else begin
          next_range_count = vec_i.msg_len;
        end
      end else if (!vec_err_i && vec_i.long_addr &&
                   vec_i.vtype == `VT_SHORT_INSTR) begin
        next_first_pend = 1'b1;
      end
    end else if (query_i && first_hit) begin
      next_first_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_pend <= 1'b0;
      first_pos <= 7'h00;
      range_start <= 7'h00;
      range_count <= 7'h00;
    end else begin
      first_pend <= next_first_pend;
      first_pos <= next_first_pos;
      range_start <= next_range_start;
      range_count <= next_range_count;
    end
  end

endmodule // msg_window

`default_nettype wire

// *** verilog/packet_link.sv ***
// serial packet link, host is master: mode 0, msb first, 32 bits per
// select. assumes sck runs well below clk_i/4 so edges survive the sync.
`default_nettype none
`include "vector_packet_formatter_cfg.svh"

module packet_link (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire vector_packet_formatter_pkg::packet_t pkt_i,
  input wire logic pkt_full_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  output logic miso_o,
  output logic done_o
);

  vector_packet_formatter_pkg::link_state_e state, next_state;
  logic [2:0] sck_sync, cs_sync;
  vector_packet_formatter_pkg::packet_t shreg, next_shreg;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic loaded, next_loaded;
  logic next_done;
  logic sck_rise, sck_fall, cs_fall, cs_rise;

  // edges come from stages two and three only
  assign sck_rise = sck_sync[1] && !sck_sync[2];
  assign sck_fall = !sck_sync[1] && sck_sync[2];
  assign cs_fall = !cs_sync[1] && cs_sync[2];
  assign cs_rise = cs_sync[1] && !cs_sync[2];
  assign miso_o = shreg[`PKT_BITS-1];

  // shifter: load at select, change data on falling sck, count rising
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_loaded = loaded;
    next_done = 1'b0;
    unique case (state)
      vector_packet_formatter_pkg::LINK_IDLE: begin
        if (cs_fall) begin
          next_shreg = pkt_i;
          next_loaded = pkt_full_i; // an empty holder reads as filler
          next_bit_cnt = 5'h00;
          next_state = vector_packet_formatter_pkg::LINK_SHIFT;
        end
      end
      vector_packet_formatter_pkg::LINK_SHIFT: begin
        if (cs_rise) begin
          next_state = vector_packet_formatter_pkg::LINK_IDLE;
        end else if (sck_rise) begin
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt == `BIT_CNT_LAST) begin
            next_done = loaded;
            next_state = vector_packet_formatter_pkg::LINK_IDLE;
          end
        end else if (sck_fall) begin
          next_shreg = {shreg[`PKT_BITS-2:0], 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= vector_packet_formatter_pkg::LINK_IDLE;
      sck_sync <= 3'h0;
      cs_sync <= 3'h7;
      shreg <= `PKT_RESET;
      bit_cnt <= 5'h00;
      loaded <= 1'b0;
      done_o <= 1'b0;
    end else begin
      state <= next_state;
      sck_sync <= {sck_sync[1:0], sck_i};
      cs_sync <= {cs_sync[1:0], cs_n_i};
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      loaded <= next_loaded;
      done_o <= next_done;
    end
  end

endmodule // packet_link

`default_nettype wire

// *** verilog/vector_packet_formatter.sv ***
// vector packet formatter top: builds 4-byte vector and message packets,
// holds one for the host link, and exposes control over wishbone.
// assumes decoder inputs share clk_i; sck and select come from pins.
//
// Function
// - byte 3 carries the vector word position in bits 6..0, bit 7 zero.
// - long-message vectors flag an error for >2 bit errors, check fail or invalid value.
// - the phase a..d is reported as 0..3 in a two-bit field.
// - long-message vectors report the frame's message word count, 1 to 85.
// - long-message vectors report where the message starts, 3 to 87.
// - on long addresses the first message word follows the vector, start points at word two.
// - short instruction packets carry vector type 001.
// - instruction data splits into byte 1 bits 5..0 and byte 0 bits 7..3, type in bits 2..0.
// - short instruction vectors flag an error for >2 bit errors or check fail.
// - a good short instruction on a long address releases one following message packet.
// - type 000 packs temporary address index and seven-bit assigned frame.
// - type 001 passes eleven event flags straight through.
// - type 010 packs address index, frame msb and message sequence number.
// - message words of an error-free vector go out as message packets by word position.
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`default_nettype none
`include "vector_packet_formatter_cfg.svh"

module vector_packet_formatter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic vec_valid_i,
  input wire vector_packet_formatter_pkg::vector_in_s vec_i,
  output logic vec_ready_o,
  input wire logic msg_valid_i,
  input wire vector_packet_formatter_pkg::msg_in_s msg_i,
  output logic msg_ready_o,
  input wire logic frame_start_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  output logic spi_miso_o,
  output logic pkt_ready_o,
  output logic irq_o
);

  // instruction data layout chosen by the instruction type
  function automatic logic [10:0] instr_data(
    input vector_packet_formatter_pkg::vector_in_s v
  );
    logic [10:0] d;
    d = v.events;
    unique case (v.itype)
      `IT_TEMP_ADDR: d = {v.tmp_addr, v.frame};
      `IT_EVENT: d = v.events;
      `IT_TEMP_SEQ: d = {v.tmp_addr, v.frame[6],
                         v.message_sequence_number};
      default: d = v.events; // reserved types carry raw bits
    endcase
    return d;
  endfunction

  // true for the vector types that carry a long message field
  function automatic logic is_long_type(input logic [2:0] t);
    return (t == `VT_SECURE) || (t == `VT_ALPHA) || (t == `VT_HEX);
  endfunction

  logic [`CTRL_WIDTH-1:0] ctrl, next_ctrl;
  logic [`IRQ_WIDTH-1:0] irq_status, next_irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask, next_irq_mask;
  logic [`IRQ_WIDTH-1:0] irq_event;
  logic [31:0] next_wb_dat;
  logic next_wb_ack;
  logic wb_req, wb_write, wb_fire;
  logic enable, flush;
  vector_packet_formatter_pkg::packet_t pkt, next_pkt;
  vector_packet_formatter_pkg::packet_t last_pkt, next_last_pkt;
  logic pkt_full, next_pkt_full;
  logic irq, next_irq;
  logic [15:0] pkt_count, next_pkt_count;
  logic [15:0] drop_count, next_drop_count;
  logic link_done;
  logic vec_take, msg_take;
  logic vec_err;
  logic in_window;
  logic msg_drop;
  vector_packet_formatter_pkg::packet_t vec_pkt, msg_pkt;
  logic [10:0] idata;

  assign enable = ctrl[`CTRL_ENABLE_BIT];
  assign flush = ctrl[`CTRL_FLUSH_BIT];

  // a single holding slot: inputs stall while it waits for the host,
  // trading throughput for no buffer; vectors win over message words
  assign vec_ready_o = enable && !pkt_full;
  assign msg_ready_o = enable && !pkt_full && !vec_valid_i;
  assign vec_take = vec_valid_i && vec_ready_o;
  assign msg_take = msg_valid_i && msg_ready_o;
  assign pkt_ready_o = pkt_full;
  assign irq_o = irq;

  // error flag depends on the vector kind
  always_comb begin
    if (vec_i.vtype == `VT_SHORT_INSTR) begin
      vec_err = vec_i.bit_err_gt2 || vec_i.check_fail;
    end else begin
      vec_err = vec_i.bit_err_gt2 || vec_i.check_fail ||
                vec_i.invalid;
    end
  end

  // vector packet assembly; unused bits stay zero for determinism
  always_comb begin
    idata = instr_data(vec_i);
    vec_pkt = `PKT_RESET;
    vec_pkt[31] = 1'b0;
    vec_pkt[30:24] = vec_i.vector_word_position;
    vec_pkt[23] = vec_err;
    vec_pkt[22:21] = vec_i.phase;
    vec_pkt[20:19] = 2'h0;
    vec_pkt[18:16] = vec_i.vtype;
    if (vec_i.vtype == `VT_SHORT_INSTR) begin
      vec_pkt[18:16] = `VT_SHORT_INSTR;
      vec_pkt[13:8] = idata[10:5];
      vec_pkt[7:3] = idata[4:0];
      vec_pkt[2:0] = vec_i.itype;
    end else if (is_long_type(vec_i.vtype)) begin
      vec_pkt[13:8] = vec_i.msg_len[6:1];
      vec_pkt[7] = vec_i.msg_len[0];
      vec_pkt[6:0] = vec_i.msg_start;
    end
  end

  // message packet assembly, identified by its own word position
  always_comb begin
    msg_pkt = `PKT_RESET;
    msg_pkt[30:24] = msg_i.vector_word_position;
    msg_pkt[23] = msg_i.bit_err_gt2;
    msg_pkt[22:21] = msg_i.phase;
    msg_pkt[20:0] = msg_i.info;
  end

  // a message word outside the live window is consumed and reported
  assign msg_drop = msg_take && !in_window;

  msg_window u_window (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(vec_take),
    .vec_i(vec_i),
    .vec_err_i(vec_err),
    .clear_i(frame_start_i || !enable),
    .query_i(msg_take),
    .pos_i(msg_i.vector_word_position),
    .match_o(in_window)
  );

  packet_link u_link (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pkt_i(pkt),
    .pkt_full_i(pkt_full),
    .sck_i(spi_sck_i),
    .cs_n_i(spi_cs_n_i),
    .miso_o(spi_miso_o),
    .done_o(link_done)
  );

  // holding slot: filled by an accepted packet, freed by the host read
  always_comb begin
    next_pkt = pkt;
    next_pkt_full = pkt_full;
    next_last_pkt = last_pkt;
    next_pkt_count = pkt_count;
    next_drop_count = drop_count;
    if (link_done || flush) begin
      next_pkt_full = 1'b0;
    end
    if (link_done) begin
      next_last_pkt = pkt;
      next_pkt_count = pkt_count + 16'h0001;
    end
    if (vec_take) begin
      next_pkt = vec_pkt;
      next_pkt_full = 1'b1;
    end else if (msg_take && in_window) begin
      next_pkt = msg_pkt;
      next_pkt_full = 1'b1;
    end
    if (msg_drop) begin
      next_drop_count = drop_count + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pkt <= `PKT_RESET;
      pkt_full <= 1'b0;
      last_pkt <= `PKT_RESET;
      pkt_count <= 16'h0000;
      drop_count <= 16'h0000;
    end else begin
      pkt <= next_pkt;
      pkt_full <= next_pkt_full;
      last_pkt <= next_last_pkt;
      pkt_count <= next_pkt_count;
      drop_count <= next_drop_count;
    end
  end

  // wishbone classic slave: one wait state, ack drops the cycle after
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_fire = wb_req && wb_ack_o;
  assign wb_write = wb_fire && wb_we_i && wb_sel_i[0];

  // events: host read done, vector error, stray message word
  always_comb begin
    irq_event = `IRQ_RESET;
    irq_event[`IRQ_SENT_BIT] = link_done;
    irq_event[`IRQ_VEC_ERR_BIT] = vec_take && vec_err;
    irq_event[`IRQ_DROP_BIT] = msg_drop;
  end

  // control, mask and sticky status; a new event beats a same-cycle clear
  always_comb begin
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_ctrl[`CTRL_FLUSH_BIT] = 1'b0; // flush is a one-shot
    if (wb_write && wb_adr_i == `REG_CTRL) begin
      next_ctrl = wb_dat_i[`CTRL_WIDTH-1:0];
    end
    if (wb_write && wb_adr_i == `REG_IRQ_MASK) begin
      next_irq_mask = wb_dat_i[`IRQ_WIDTH-1:0];
    end
    if (wb_write && wb_adr_i == `REG_IRQ_STATUS) begin
      next_irq_status = irq_status & ~wb_dat_i[`IRQ_WIDTH-1:0];
    end
    next_irq_status = next_irq_status | irq_event;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // read mux, sampled with ack so data stands while ack is high
  always_comb begin
    next_wb_ack = wb_req && !wb_ack_o;
    next_wb_dat = 32'h0000_0000;
    unique case (wb_adr_i)
      `REG_CTRL: next_wb_dat[`CTRL_WIDTH-1:0] = ctrl;
      `REG_IRQ_STATUS: next_wb_dat[`IRQ_WIDTH-1:0] = irq_status;
      `REG_IRQ_MASK: next_wb_dat[`IRQ_WIDTH-1:0] = irq_mask;
      `REG_LAST_PKT: next_wb_dat = last_pkt;
      `REG_PKT_COUNT: next_wb_dat = {drop_count, pkt_count};
      `REG_LEVEL: next_wb_dat[0] = pkt_full;
      default: next_wb_dat = 32'h0000_0000; // unmapped reads zero
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
      irq_mask <= `IRQ_RESET;
      irq_status <= `IRQ_RESET;
      irq <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      irq_mask <= next_irq_mask;
      irq_status <= next_irq_status;
      irq <= next_irq;
      wb_ack_o <= next_wb_ack;
      wb_dat_o <= next_wb_dat;
    end
  end

endmodule // vector_packet_formatter

`default_nettype wire

// *** verification/vector_packet_formatter_props.sv ***
// checker of the formatter, watching its top ports only.
// assumes one clock and a synchronous active high reset.
`default_nettype none
module vector_packet_formatter_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic vec_valid_i,
  input wire logic vec_ready_o,
  input wire logic msg_ready_o,
  input wire logic spi_cs_n_i,
  input wire logic pkt_ready_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // new request, taken vector, slot idle on both sides
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence take_s;
    vec_valid_i && vec_ready_o;
  endsequence
  sequence idle_full_s;
    (spi_cs_n_i && !wb_cyc_i && pkt_ready_o)[*8];
  endsequence

  AST_ACK_ANSWER: assert property (req_s |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("stray ack");
  // reset must not disable its own check
  AST_RESET_OUT: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !pkt_ready_o && !irq_o && !vec_ready_o)
    else $error("reset left outputs");
  AST_TAKE_PKT: assert property (take_s |=> pkt_ready_o && !vec_ready_o)
    else $error("no packet");
  AST_FULL_BLOCK: assert property (pkt_ready_o |-> !vec_ready_o && !msg_ready_o)
    else $error("ready while full");
  AST_VEC_FIRST: assert property (vec_valid_i |-> !msg_ready_o)
    else $error("message beside vector");
  AST_PKT_HOLD: assert property (idle_full_s |=> pkt_ready_o)
    else $error("packet lost");
endmodule // vector_packet_formatter_props

bind vector_packet_formatter vector_packet_formatter_props props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .vec_valid_i(vec_valid_i), .vec_ready_o(vec_ready_o),
  .msg_ready_o(msg_ready_o), .spi_cs_n_i(spi_cs_n_i),
  .pkt_ready_o(pkt_ready_o), .irq_o(irq_o));
`default_nettype wire

// *** verification/host_spi_model.sv ***
// host model: mode 0 link master, one 32-bit packet per start.
// assumes the formatter samples sck with a faster clock.
`default_nettype none
module host_spi_model (
  input wire logic start_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic got_o,
  output var vector_packet_formatter_pkg::packet_t data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: sck low, select released
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    got_o = 1'b0;
    data_o = 32'h0000_0000;
  end

  // sck runs only while selected; a half period hides the sync delay
  always @(posedge start_i) begin
    #13 cs_n_o = 1'b0;
    #160;
    for (int i = 31; i >= 0; i--) begin
      sck_o = 1'b1;
      data_o[i] = miso_i; // unused bits as seen
      #80 sck_o = 1'b0;
      #80;
    end
    cs_n_o = 1'b1;
    // bench masks reserved data
    got_o = 1'b1;
    #20 got_o = 1'b0;
  end
endmodule // host_spi_model
`default_nettype wire

// *** verification/vector_packet_formatter_tb.sv ***
// self-checking bench of the vector packet formatter with a host model.
// assumes the design package, its config header and host_spi_model.
`default_nettype none
`include "vector_packet_formatter_cfg.svh"
module vector_packet_formatter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [31:0] p;
    logic [31:0] m;
  } note_s;
  typedef vector_packet_formatter_pkg::vector_in_s vword_s;
  typedef vector_packet_formatter_pkg::msg_in_s mword_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic vec_valid_i = 1'b0;
  logic msg_valid_i = 1'b0;
  vword_s vec_i = '0;
  mword_s msg_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, vec_ready_o, msg_ready_o, sck, cs_n, miso;
  logic pkt_ready_o, irq_o, got;
  logic start = 1'b0;
  logic [31:0] host_data;
  logic [31:0] seed = 32'hfe9d_1bc1;
  logic [31:0] q;
  note_s notes[$];
  int errors = 0;
  int comparisons = 0;

  // 50 MHz system clock
  always #10 clk_i = ~clk_i;

  vector_packet_formatter uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vec_valid_i(vec_valid_i),
    .vec_i(vec_i), .vec_ready_o(vec_ready_o), .msg_valid_i(msg_valid_i),
    .msg_i(msg_i), .msg_ready_o(msg_ready_o), .frame_start_i(1'b0),
    .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_miso_o(miso),
    .pkt_ready_o(pkt_ready_o), .irq_o(irq_o));
  host_spi_model host (.start_i(start), .miso_i(miso), .sck_o(sck),
    .cs_n_o(cs_n), .got_o(got), .data_o(host_data));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected vector packet, field by field
  function automatic logic [31:0] vexp(vword_s v);
    logic e;
    logic [10:0] d;
    if (v.vtype == 3'h1) begin
      e = v.bit_err_gt2 | v.check_fail;
      case (v.itype)
        3'h0: d = {v.tmp_addr, v.frame};
        3'h2: d = {v.tmp_addr, v.frame[6], v.message_sequence_number};
        default: d = v.events;
      endcase
      return {1'b0, v.vector_word_position, e, v.phase, 2'b00, 3'h1,
        2'b00, d, v.itype};
    end
    e = v.bit_err_gt2 | v.check_fail | v.invalid;
    return {1'b0, v.vector_word_position, e, v.phase, 2'b00, v.vtype,
      2'b00, v.msg_len, v.msg_start};
  endfunction

  function automatic logic [31:0] mexp(mword_s w);
    return {1'b0, w.vector_word_position, w.bit_err_gt2, w.phase, w.info};
  endfunction

  task automatic chk(input string name, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic timeout();
    errors++;
    $display("[ERR] wait expected done seen hang");
    end_of_test();
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) timeout();
  endtask

  task automatic wb_rd(input logic [7:0] a, input logic [31:0] e,
      input string name);
    logic [31:0] rd;
    wb(1'b0, a, 32'h0000_0000, rd);
    chk(name, e, rd);
  endtask

  // offer a word; when read is set, note its packet and have the host read it
  task automatic offer(input logic is_msg, input vword_s v, input mword_s w,
      input logic [31:0] e, m, input logic read);
    int n;
    @(posedge clk_i);
    vec_i <= v;
    msg_i <= w;
    if (is_msg) msg_valid_i <= 1'b1;
    else vec_valid_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((is_msg ? msg_ready_o : vec_ready_o) !== 1'b1 && n < 50);
    vec_valid_i <= 1'b0;
    msg_valid_i <= 1'b0;
    if (n >= 50) timeout();
    if (read) begin
      notes.push_back('{e, m});
      // slot stays full while nobody reads it
      repeat (12) @(posedge clk_i);
      if (pkt_ready_o !== 1'b1) timeout();
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      for (n = 0; (pkt_ready_o | !got) !== 1'b0; n++) begin
        if (n > 1500) timeout();
        @(posedge clk_i);
      end
    end else
      repeat (4) @(posedge clk_i);
  endtask

  // match each host read with the oldest note
  always @(posedge got) begin
    note_s n;
    n = notes.pop_front();
    chk("packet", n.p & n.m, host_data & n.m);
  end

  initial begin
    vword_s v;
    mword_s w;
    logic [63:0] r;
    logic [2:0] vts [3];
    vts = '{3'h0, 3'h5, 3'h6};
    w = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped address, unmask, enable
    wb_rd(`REG_CTRL, 32'h0000_0000, "ctrl");
    wb_rd(`REG_IRQ_MASK, 32'h0000_0000, "mask");
    wb_rd(`REG_LEVEL, 32'h0000_0000, "level");
    wb_rd(8'h40, 32'h0000_0000, "unmapped");
    wb(1'b1, `REG_IRQ_MASK, 32'h0000_0007, q);
    wb(1'b1, `REG_CTRL, 32'h0000_0001, q);
    wb_rd(`REG_IRQ_MASK, 32'h0000_0007, "mask");
    // long types at field bounds, first with no error cause, then one cause each
    for (int i = 0; i < 4; i++) begin
      r = {rnd(), rnd()};
      v = r[60:0];
      v.vtype = vts[i % 3];
      v.phase = i[1:0];
      v.vector_word_position = i[0] ? 7'h57 : 7'h02;
      v.msg_len = i[0] ? 7'h55 : 7'h01;
      v.msg_start = i[0] ? 7'h57 : 7'h03;
      {v.bit_err_gt2, v.check_fail, v.invalid} = i ? 3'h1 << (i - 1) : 3'h0;
      offer(1'b0, v, w, vexp(v), 32'hFFE7_3FFF, 1'b1);
    end
    // every instruction type; invalid alone is no error here
    for (int i = 0; i < 8; i++) begin
      r = {rnd(), rnd()};
      v = r[60:0];
      v.vtype = 3'h1;
      v.itype = i[2:0];
      v.invalid = 1'b1;
      v.vector_word_position = {4'h2, i[2:0]};
      offer(1'b0, v, w, vexp(v),
        i > 2 ? 32'hFFE7_0007 : 32'hFFE7_3FFF, 1'b1);
    end
    // long address: word after vector, then range
    v.vtype = 3'h5;
    v.long_addr = 1'b1;
    {v.bit_err_gt2, v.check_fail, v.invalid} = 3'h0;
    v.vector_word_position = 7'h0A;
    v.msg_len = 7'h03;
    v.msg_start = 7'h14;
    offer(1'b0, v, w, vexp(v), 32'hFFE7_3FFF, 1'b1);
    r = {rnd(), rnd()};
    w = r[30:0];
    w.vector_word_position = 7'h0B;
    offer(1'b1, v, w, mexp(w), 32'hFFFF_FFFF, 1'b1);
    w.vector_word_position = 7'h32;
    offer(1'b1, v, w, 32'h0, 32'h0, 1'b0);
    w.vector_word_position = 7'h14;
    offer(1'b1, v, w, mexp(w), 32'hFFFF_FFFF, 1'b1);
    // good instruction on long address frees next word
    v.vtype = 3'h1;
    v.itype = 3'h2;
    v.vector_word_position = 7'h1E;
    offer(1'b0, v, w, vexp(v), 32'hFFE7_3FFF, 1'b1);
    w.vector_word_position = 7'h1F;
    offer(1'b1, v, w, mexp(w), 32'hFFFF_FFFF, 1'b1);
    // all events latched; 17 packets read, 1 word dropped
    wb_rd(`REG_IRQ_STATUS, 32'h0000_0007, "status");
    @(posedge clk_i);
    chk("irq", 32'h1, {31'h0, irq_o});
    wb_rd(`REG_PKT_COUNT, 32'h0001_0011, "count");
    wb(1'b1, `REG_IRQ_STATUS, 32'h0000_0007, q);
    wb(1'b1, `REG_IRQ_MASK, 32'h0000_0002, q);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    // clean vector: only the now masked sent bit
    v.itype = 3'h0;
    offer(1'b0, v, w, vexp(v), 32'hFFE7_3FFF, 1'b1);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wb_rd(`REG_IRQ_STATUS, 32'h0000_0001, "status");
    wb_rd(`REG_LAST_PKT, vexp(v), "last");
    chk("pending notes", 32'h0, notes.size());
    end_of_test();
  end
endmodule // vector_packet_formatter_tb
`default_nettype wire
